// ---- gpb_pkg.sv ----
// Purpose: Shared constants and types for the GPIO pin configuration bank
// Assumes: 16-bit register data, 8-bit register addresses
// Notes:   Reset values of CONFIG-dependent fields are plain defaults
package gpb_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int           GPB_PINS      = 13;
  localparam int           GPB_DW        = 16;
  localparam int           GPB_AW        = 8;
  localparam int           GPB_FW        = 4;
  localparam logic [3:0]   GPB_FN_GPIO   = 4'h0;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0]   GPB_OFS_PULLUP  = 8'h81;
  localparam logic [7:0]   GPB_OFS_PULLDN  = 8'h82;
  localparam logic [7:0]   GPB_OFS_EDGE    = 8'h83;
  localparam logic [7:0]   GPB_OFS_DIR     = 8'h86;
  localparam logic [7:0]   GPB_OFS_POL     = 8'h87;
  localparam logic [7:0]   GPB_OFS_LEVEL   = 8'hE6;
  localparam logic [7:0]   GPB_OFS_IRQFLAG = 8'h1E;
  localparam logic [7:0]   GPB_OFS_IRQMASK = 8'h26;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [12:0]  GPB_RST_PULLUP = 13'h0000;
  localparam logic [12:0]  GPB_RST_PULLDN = 13'h0000;
  localparam logic [12:0]  GPB_RST_EDGE   = 13'h0000;
  localparam logic [12:0]  GPB_RST_DIR    = 13'h1FFF;
  localparam logic [12:0]  GPB_RST_POL    = 13'h1FFF;
  localparam logic [12:0]  GPB_RST_LEVEL  = 13'h0000;
  localparam logic [12:0]  GPB_RST_MASK   = 13'h1FFF;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [7:0]        addr;
    logic [15:0]       wdata;
  } gpb_reg_req_t;

  typedef struct packed {
    logic              valid;
    logic [15:0]       rdata;
  } gpb_reg_rsp_t;

endpackage : gpb_pkg

// ---- gpb_pin_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of pin inputs
// Assumes: Bits are independent levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module gpb_pin_sync #(
  parameter int WIDTH = 13
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import gpb_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_stage1  = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule : gpb_pin_sync

// ---- gpb_pin_bank.sv ----
// Purpose: Thirteen-pin GPIO bank with configuration registers and edge interrupts
// Assumes: Register port is the device control interface, one access per cycle
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/100ps
module gpb_pin_bank #(
  parameter logic [12:0] RST_PULLUP = gpb_pkg::GPB_RST_PULLUP,
  parameter logic [12:0] RST_PULLDN = gpb_pkg::GPB_RST_PULLDN,
  parameter logic [12:0] RST_DIR    = gpb_pkg::GPB_RST_DIR,
  parameter logic [12:0] RST_POL    = gpb_pkg::GPB_RST_POL
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register access
  input  wire gpb_pkg::gpb_reg_req_t regReq,
  output gpb_pkg::gpb_reg_rsp_t     regRsp,
  // Function selection from the alternate-function map
  input  wire logic [12:0][3:0]     pinFunctionSelect,
  input  wire logic [12:0]          invertedSenseFn,
  // Pins
  input  wire logic [12:0]          pinIn,
  output logic      [12:0]          pinOut,
  output logic      [12:0]          pinOe,
  output logic      [12:0]          pinPullupEn,
  output logic      [12:0]          pinPulldownEn,
  // Alternate input functions and interrupt
  output logic      [12:0]          altFuncAsserted,
  output logic                      irqOut
);
  import gpb_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [12:0] polAdjust(input logic [12:0] lvl, input logic [12:0] hi);
    polAdjust = ~(lvl ^ hi);
  endfunction : polAdjust

  function automatic logic [12:0] low13(input logic [15:0] d);
    low13 = d[12:0];
  endfunction : low13

  // ****************************************
  // State
  // ****************************************
  logic [12:0] pullupReg, pulldnReg, edgeReg, dirReg, polReg, levelReg;
  logic [12:0] flagReg, maskReg, prevAdj;
  logic [12:0] next_pullup, next_pulldn, next_edge, next_dir, next_pol, next_level;
  logic [12:0] next_flag, next_mask, next_prevAdj;
  logic [12:0] next_pinOut, next_pinOe, next_pu, next_pd, next_alt;
  logic        next_irq;
  gpb_reg_rsp_t next_rsp;
  logic [12:0] pinSync, adj, isGpio, riseEv, fallEv, edgeEv, lvlClr;
  logic        wrLevel;

  gpb_pin_sync #(.WIDTH(GPB_PINS)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  // ****************************************
  // Event detection
  // ****************************************
  always_comb begin
    for (int i = 0; i < GPB_PINS; i++) begin
      isGpio[i] = (pinFunctionSelect[i] == GPB_FN_GPIO);
    end
    adj     = polAdjust(pinSync, polReg);
    riseEv  = adj & ~prevAdj & dirReg & isGpio;
    fallEv  = ~adj & prevAdj & dirReg & isGpio & edgeReg;
    edgeEv  = riseEv | fallEv;
    wrLevel = regReq.wr && (regReq.addr == GPB_OFS_LEVEL);
    lvlClr  = wrLevel ? (dirReg & ~low13(regReq.wdata)) : '0;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_comb begin
    next_pullup  = pullupReg;
    next_pulldn  = pulldnReg;
    next_edge    = edgeReg;
    next_dir     = dirReg;
    next_pol     = polReg;
    next_level   = levelReg;
    next_mask    = maskReg;
    next_prevAdj = adj;
    next_flag    = flagReg;
    if (regReq.wr) begin
      case (regReq.addr)
        GPB_OFS_PULLUP:  next_pullup = low13(regReq.wdata);
        GPB_OFS_PULLDN:  next_pulldn = low13(regReq.wdata);
        GPB_OFS_EDGE:    next_edge   = low13(regReq.wdata);
        GPB_OFS_DIR:     next_dir    = low13(regReq.wdata);
        GPB_OFS_POL:     next_pol    = low13(regReq.wdata);
        GPB_OFS_IRQMASK: next_mask   = low13(regReq.wdata);
        GPB_OFS_LEVEL: begin
          next_level = (levelReg & dirReg) | (low13(regReq.wdata) & ~dirReg);
        end
        default: next_level = levelReg;
      endcase
    end
    if (regReq.rd && (regReq.addr == GPB_OFS_IRQFLAG)) begin
      next_flag = '0;
    end
    // Set beats any clear in the same cycle
    next_flag = (next_flag & ~lvlClr) | edgeEv;
  end

  always_comb begin
    next_rsp.valid = regReq.rd;
    next_rsp.rdata = '0;
    if (regReq.rd) begin
      case (regReq.addr)
        GPB_OFS_PULLUP:  next_rsp.rdata = {3'h0, pullupReg};
        GPB_OFS_PULLDN:  next_rsp.rdata = {3'h0, pulldnReg};
        GPB_OFS_EDGE:    next_rsp.rdata = {3'h0, edgeReg};
        GPB_OFS_DIR:     next_rsp.rdata = {3'h0, dirReg};
        GPB_OFS_POL:     next_rsp.rdata = {3'h0, polReg};
        GPB_OFS_IRQMASK: next_rsp.rdata = {3'h0, maskReg};
        GPB_OFS_IRQFLAG: next_rsp.rdata = {3'h0, flagReg};
        GPB_OFS_LEVEL:   next_rsp.rdata = {3'h0,
                                           (pinSync & dirReg) | (levelReg & ~dirReg)};
        default:         next_rsp.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // Pin drive and outputs
  // ****************************************
  always_comb begin
    next_pinOut = levelReg & ~polReg;
    next_pinOe  = ~dirReg & (~polReg | ~levelReg);
    next_pu     = pullupReg & dirReg;
    next_pd     = pulldnReg & dirReg;
    next_alt    = invertedSenseFn & ~(pinSync ^ ~polReg) | ~invertedSenseFn & adj;
    next_irq    = |(flagReg & ~maskReg);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pullupReg       <= RST_PULLUP;
      pulldnReg       <= RST_PULLDN;
      edgeReg         <= GPB_RST_EDGE;
      dirReg          <= RST_DIR;
      polReg          <= RST_POL;
      levelReg        <= GPB_RST_LEVEL;
      maskReg         <= GPB_RST_MASK;
      flagReg         <= '0;
      prevAdj         <= ~RST_POL;
      regRsp          <= '0;
      pinOut          <= '0;
      pinOe           <= '0;
      pinPullupEn     <= '0;
      pinPulldownEn   <= '0;
      altFuncAsserted <= '0;
      irqOut          <= 1'b0;
    end else begin
      pullupReg       <= next_pullup;
      pulldnReg       <= next_pulldn;
      edgeReg         <= next_edge;
      dirReg          <= next_dir;
      polReg          <= next_pol;
      levelReg        <= next_level;
      maskReg         <= next_mask;
      flagReg         <= next_flag;
      prevAdj         <= next_prevAdj;
      regRsp          <= next_rsp;
      pinOut          <= next_pinOut;
      pinOe           <= next_pinOe;
      pinPullupEn     <= next_pu;
      pinPulldownEn   <= next_pd;
      altFuncAsserted <= next_alt;
      irqOut          <= next_irq;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_lvlRead;
    regReq.rd && (regReq.addr == GPB_OFS_LEVEL) && (dirReg == 13'h1FFF);
  endsequence

  sequence s_lvlClear;
    wrLevel && (regReq.wdata[0] == 1'b0) && dirReg[0] && !edgeEv[0];
  endsequence

  property p_irqOr;
    @(posedge clk) disable iff (rst) ((flagReg & ~maskReg) != 13'h0000) |=> irqOut;
  endproperty
  a_irqOr: assert property (p_irqOr) else $error("irq not OR of unmasked flags");

  property p_irqQuiet;
    @(posedge clk) disable iff (rst) ((flagReg & ~maskReg) == 13'h0000) |=> !irqOut;
  endproperty
  a_irqQuiet: assert property (p_irqQuiet) else $error("irq without unmasked flag");

  property p_maskBlock;
    @(posedge clk) disable iff (rst) (maskReg == 13'h1FFF) |=> !irqOut;
  endproperty
  a_maskBlock: assert property (p_maskBlock) else $error("masked flag raised irq");

  property p_riseSets;
    @(posedge clk) disable iff (rst)
      (riseEv != 13'h0000) |=> ((flagReg & $past(riseEv)) == $past(riseEv));
  endproperty
  a_riseSets: assert property (p_riseSets) else $error("rising edge lost");

  property p_fallMode;
    @(posedge clk) disable iff (rst)
      (dirReg[0] && !edgeReg[0] && !flagReg[0] && !adj[0] && prevAdj[0]) |=> !flagReg[0];
  endproperty
  a_fallMode: assert property (p_fallMode) else $error("falling edge flagged");

  property p_pushPull;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((pinOe & ~$past(dirReg) & ~$past(polReg)) == (~$past(dirReg) & ~$past(polReg)));
  endproperty
  a_pushPull: assert property (p_pushPull) else $error("push-pull output not driven");

  property p_openDrain;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((pinOe & pinOut & ~$past(dirReg) & $past(polReg)) == 13'h0000);
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("open-drain drove high");

  property p_levelDrive;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((pinOut & ~$past(dirReg) & ~$past(polReg)) ==
                ($past(levelReg) & ~$past(dirReg) & ~$past(polReg)));
  endproperty
  a_levelDrive: assert property (p_levelDrive) else $error("output level mismatch");

  property p_readBack;
    @(posedge clk) disable iff (rst)
      s_lvlRead |=> (regRsp.valid && regRsp.rdata[12:0] == $past(pinSync));
  endproperty
  a_readBack: assert property (p_readBack) else $error("input read-back wrong");

  property p_lvlClear;
    @(posedge clk) disable iff (rst) s_lvlClear |=> !flagReg[0];
  endproperty
  a_lvlClear: assert property (p_lvlClear) else $error("level write did not clear flag");

  property p_pullInput;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (((pinPullupEn | pinPulldownEn) & ~$past(dirReg)) == 13'h0000);
  endproperty
  a_pullInput: assert property (p_pullInput) else $error("pull enabled on output");

endmodule : gpb_pin_bank

// ---- gpb_pin_world.sv ----
// Purpose: Pins, switches and pulls outside the bank
// Assumes: Switches never fight an enabled driver
// Notes:   Floating pins toggle every cycle
`timescale 1ns/100ps
module gpb_pin_world (
  // Clock
  input  wire logic        clk,
  // Bank side
  input  wire logic [12:0] pinOut,
  input  wire logic [12:0] pinOe,
  input  wire logic [12:0] pinPullupEn,
  input  wire logic [12:0] pinPulldownEn,
  // Switches
  input  wire logic [12:0] extVal,
  input  wire logic [12:0] extEn,
  output logic      [12:0] pinIn
);
  // ****************************************
  // Wire resolution
  // ****************************************
  logic [12:0] floatPat = 13'h0AAA;
  always @(posedge clk) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extVal[i];
      else if (pinPullupEn[i]) pinIn[i] = 1'b1;
      else if (pinPulldownEn[i]) pinIn[i] = 1'b0;
      else pinIn[i] = floatPat[i];
    end
  end
endmodule : gpb_pin_world

// ---- gpio_pin_config_bank_test.sv ----
// Purpose: Self-checking bench for the pin bank
// Assumes: Switches drive every pin unless an output drives it
// Notes:   Random values from a fixed seed
`timescale 1ns/100ps
module gpio_pin_config_bank_test;
  import gpb_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic             clk, rst, irqOut;
  gpb_reg_req_t     regReq;
  gpb_reg_rsp_t     regRsp;
  logic [12:0][3:0] fnSel;
  logic [12:0]      invSense, pinIn, pinOut, pinOe, puEn, pdEn, altAsserted, extVal, extEn;
  logic [12:0]      lvl, pol, dir, edg, pu, pd, oldPin, expFlag;
  logic [15:0]      rd;
  logic [7:0]       ofs [7] = '{8'h81, 8'h82, 8'h83, 8'h86, 8'h87, 8'h26, 8'h00};
  logic [12:0]      rstv [7] = '{13'h0, 13'h0, 13'h0, 13'h1FFF, 13'h1FFF, 13'h1FFF, 13'h0};
  int               num_errors = 0, num_checks = 0, seed = 19, cycles = 0;

  gpb_pin_bank u_dut (.clk(clk), .rst(rst), .regReq(regReq), .regRsp(regRsp),
    .pinFunctionSelect(fnSel), .invertedSenseFn(invSense), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullupEn(puEn), .pinPulldownEn(pdEn), .altFuncAsserted(altAsserted),
    .irqOut(irqOut));
  gpb_pin_world u_world (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinPullupEn(puEn),
    .pinPulldownEn(pdEn), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val
  task automatic reg_write(input logic [7:0] a, input logic [12:0] d);
    @(posedge clk);
    #1 regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: {3'h0, d}};
    @(posedge clk);
    #1 regReq = '0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    #1 regReq = '0;
    d = regRsp.rdata;
    check_val({15'h0, regRsp.valid}, 16'h0001);
  endtask : reg_read
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Asserted level: follows the pin when the sense bit is one
  function automatic logic [12:0] adj(input logic [12:0] p, input logic [12:0] s);
    return ~(p ^ s);
  endfunction : adj
  function automatic logic [12:0] flags(input logic [12:0] a, b, s, m);
    return (~adj(a, s) & adj(b, s)) | (m & adj(a, s) & ~adj(b, s));
  endfunction : flags

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    regReq = '0;
    fnSel = '0;
    invSense = '0;
    extVal = '0;
    extEn = 13'h1FFF;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    check_val({3'h0, pinOe}, 16'h0000);
    foreach (ofs[i]) begin
      reg_read(ofs[i], rd);
      check_val(rd, {3'h0, rstv[i]});
    end
    // Outputs, pulls and read-back with mixed directions
    repeat (6) begin
      dir = 13'($random(seed));
      pol = 13'($random(seed));
      lvl = 13'($random(seed));
      pu = 13'($random(seed));
      pd = ~pu & 13'($random(seed));
      extVal = 13'($random(seed));
      reg_write(GPB_OFS_POL, pol);
      reg_write(GPB_OFS_DIR, dir);
      reg_write(GPB_OFS_LEVEL, lvl);
      reg_write(GPB_OFS_PULLUP, pu);
      reg_write(GPB_OFS_PULLDN, pd);
      settle(2);
      check_val({3'h0, pinOe}, {3'h0, ~dir & (~pol | ~lvl)});
      check_val({3'h0, pinOut & ~dir}, {3'h0, ~dir & ~pol & lvl});
      check_val({3'h0, puEn}, {3'h0, pu & dir});
      check_val({3'h0, pdEn}, {3'h0, pd & dir});
      settle(3);
      reg_read(GPB_OFS_LEVEL, rd);
      check_val(rd, {3'h0, (~dir & lvl) | (dir & extVal)});
    end
    // Edge flags with all inputs, pin 0 on another function
    reg_write(GPB_OFS_DIR, 13'h1FFF);
    reg_write(GPB_OFS_IRQMASK, 13'h0000);
    fnSel[0] = 4'h3;
    repeat (8) begin
      pol = 13'($random(seed));
      edg = 13'($random(seed));
      invSense = {12'h0, 1'($random(seed))};
      reg_write(GPB_OFS_POL, pol);
      reg_write(GPB_OFS_EDGE, edg);
      settle(6);
      reg_read(GPB_OFS_IRQFLAG, rd);
      oldPin = extVal;
      extVal = 13'($random(seed));
      settle(6);
      expFlag = flags(oldPin, extVal, pol, edg) & 13'h1FFE;
      check_val({15'h0, irqOut}, {15'h0, |expFlag});
      check_val({3'h0, altAsserted}, {3'h0, adj(extVal, pol ^ invSense)});
      reg_read(GPB_OFS_LEVEL, rd);
      check_val(rd, {3'h0, extVal});
      reg_read(GPB_OFS_IRQFLAG, rd);
      check_val(rd, {3'h0, expFlag});
    end
    // Masked flags, unmask, then clear by level write
    fnSel[0] = 4'h0;
    reg_write(GPB_OFS_POL, 13'h1FFF);
    reg_write(GPB_OFS_EDGE, 13'h1FFF);
    reg_write(GPB_OFS_IRQMASK, 13'h1FFF);
    settle(6);
    reg_read(GPB_OFS_IRQFLAG, rd);
    extVal = ~extVal;
    settle(6);
    check_val({15'h0, irqOut}, 16'h0000);
    reg_write(GPB_OFS_IRQMASK, 13'h1FFE);
    settle(2);
    check_val({15'h0, irqOut}, 16'h0001);
    reg_write(GPB_OFS_LEVEL, 13'h0000);
    settle(2);
    check_val({15'h0, irqOut}, 16'h0000);
    reg_read(GPB_OFS_IRQFLAG, rd);
    check_val(rd, 16'h0000);
    tally_and_finish();
  end
endmodule : gpio_pin_config_bank_test
